// ==== design/sps_port_status.sv ====
`timescale 1ns/1ps
// What this block does
// - flush command empties input buffer completely
// - read and write completion events are reported
// - status returns flag word and unread count
// - read busy set on start, cleared at end
// - read success set on done, cleared on start
// - read timeout set on timeout, cleared on start
// - write busy set on start, cleared at end
// - write success set on done, cleared on start
// - write timeout set on timeout, cleared on start
// - data present high while buffer not empty
// - overrun, framing, parity latch until status read
// - clear to send bit, active without line
// - flag bits four to zero read zero
// - snapshot stored as 32 bits or two words
// - control word bit 15 sets RTS level
// - RS-485 RTS gated by transmit driver enable
// - multi-drop modes drive only while transmitting
// - point-to-point keeps driver always enabled
// - input buffer is a sized fifo
module sps_port_status #(
   parameter int BUF_DEPTH = sps_pkg::BUF_DEPTH,
   parameter bit HAS_CTS = 1'b1,
   parameter bit IS_RS485 = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [15:0] cmd_code,
   input wire logic [15:0] cmd_arg0,
   input wire logic [15:0] cmd_arg1,
   output logic cmd_done,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_overrun,
   input wire logic rx_frame_err,
   input wire logic rx_parity_err,
   input wire logic pop_req,
   output logic pop_ack,
   output logic [7:0] pop_data,
   input wire logic rd_start,
   input wire logic rd_done,
   input wire logic rd_timeout,
   input wire logic rd_cancel,
   input wire logic wr_start,
   input wire logic wr_done,
   input wire logic wr_timeout,
   input wire logic wr_cancel,
   input wire logic tx_active,
   input wire logic [1:0] duplex_mode,
   input wire logic cts_pin,
   output logic rts_line,
   output logic tx_drv_en,
   output logic st_valid,
   input wire logic st_ready,
   output logic st_bit_mode,
   output logic [15:0] st_addr,
   output logic [15:0] st_data
);
   localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(BUF_DEPTH - 1);
   localparam logic [AW:0] FULL = (AW + 1)'(BUF_DEPTH);

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      wrap_inc = (p == LAST) ? '0 : p + 1'b1;
   endfunction : wrap_inc

   function automatic logic is_cmd(input logic [15:0] c,
                                   input logic [15:0] k);
      is_cmd = (c == k);
   endfunction : is_cmd

   // ****************************************
   // command decode
   // ****************************************
   sps_pkg::sps_state_t state;
   sps_pkg::sps_state_t next_state;
   wire cmd_take = cmd_valid && cmd_ready;
   wire flush = cmd_take && is_cmd(cmd_code, sps_pkg::CMD_FLUSH);
   wire status_take = cmd_take && is_cmd(cmd_code, sps_pkg::CMD_STATUS);
   wire ctrl_take = cmd_take && is_cmd(cmd_code, sps_pkg::CMD_CTRL);
   assign cmd_ready = (state == sps_pkg::ST_IDLE);

   // ****************************************
   // input buffer
   // ****************************************
   logic [7:0] fifo_mem [BUF_DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] count;
   wire full = (count == FULL);
   wire empty = (count == '0);
   wire push = rx_valid && !full && !flush;
   wire pop = pop_req && !empty && !flush;
   wire buf_overrun = rx_valid && full && !flush;
   wire [15:0] count16 = 16'(count);

   always_ff @(posedge ref_clk) begin
      if (push) begin
         fifo_mem[wp] <= rx_data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         count <= '0;
      end else if (flush) begin
         wp <= '0;
         rp <= '0;
         count <= '0;
      end else begin
         if (push) wp <= wrap_inc(wp);
         if (pop) rp <= wrap_inc(rp);
         count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pop_ack <= 1'b0;
         pop_data <= 8'h00;
      end else begin
         pop_ack <= pop;
         if (pop) pop_data <= fifo_mem[rp];
      end
   end

   // ****************************************
   // flag word
   // ****************************************
   logic read_in_progress, read_done_ok, read_timed_out;
   logic write_busy, write_done_ok, write_timed_out;
   logic overrun_flag, frame_err, parity_err;
   logic cts_meta, cts_sync;
   wire rd_end = rd_done || rd_timeout || rd_cancel;
   wire wr_end = wr_done || wr_timeout || wr_cancel;
   wire ovf_set = rx_overrun || buf_overrun;
   wire next_read_in_progress = rd_start || (read_in_progress && !rd_end);
   wire next_read_done_ok = rd_done || (read_done_ok && !rd_start);
   wire next_read_timed_out = rd_timeout || (read_timed_out && !rd_start);
   wire next_write_busy = wr_start || (write_busy && !wr_end);
   wire next_write_done_ok = wr_done || (write_done_ok && !wr_start);
   wire next_write_timed_out = wr_timeout || (write_timed_out && !wr_start);
   wire next_overrun_flag = ovf_set || (overrun_flag && !status_take);
   wire next_frame_err = rx_frame_err || (frame_err && !status_take);
   wire next_parity_err = rx_parity_err || (parity_err && !status_take);
   wire rx_data_present = !empty;
   wire clear_to_send_seen = HAS_CTS ? cts_sync : 1'b1;
   wire [15:0] flag_word = {read_in_progress, read_done_ok, read_timed_out,
                            write_busy, write_done_ok, write_timed_out,
                            rx_data_present, overrun_flag, frame_err,
                            parity_err, clear_to_send_seen,
                            sps_pkg::UNUSED_BITS};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {read_in_progress, read_done_ok, read_timed_out} <=
            {3{sps_pkg::RST_FLAG}};
         {write_busy, write_done_ok, write_timed_out} <=
            {3{sps_pkg::RST_FLAG}};
         {overrun_flag, frame_err, parity_err} <=
            {3{sps_pkg::RST_FLAG}};
      end else begin
         {read_in_progress, read_done_ok, read_timed_out} <=
            {next_read_in_progress, next_read_done_ok, next_read_timed_out};
         {write_busy, write_done_ok, write_timed_out} <=
            {next_write_busy, next_write_done_ok, next_write_timed_out};
         {overrun_flag, frame_err, parity_err} <=
            {next_overrun_flag, next_frame_err, next_parity_err};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cts_meta <= 1'b0;
         cts_sync <= 1'b0;
      end else begin
         cts_meta <= cts_pin;
         cts_sync <= cts_meta;
      end
   end

   // ****************************************
   // status snapshot sequencer
   // ****************************************
   logic [15:0] snap_flags;
   logic [15:0] snap_count;
   logic dest_bit;
   logic [15:0] dest_off;
   sps_beat_if #(.W(sps_pkg::BEAT_W)) beat_in ();
   sps_beat_if #(.W(sps_pkg::BEAT_W)) beat_out ();
   wire beat_take = beat_in.valid && beat_in.ready;
   wire in_word1 = (state == sps_pkg::ST_WORD1);
   wire [15:0] stride = dest_bit ? sps_pkg::BIT_STRIDE
                                 : sps_pkg::WORD_STRIDE;
   wire [15:0] beat_addr = in_word1 ? dest_off : dest_off + stride;
   wire [15:0] beat_word = in_word1 ? snap_flags : snap_count;
   assign beat_in.valid = (state != sps_pkg::ST_IDLE);
   assign beat_in.data = {dest_bit, beat_addr, beat_word};

   always_comb begin
      next_state = state;
      case (state)
         sps_pkg::ST_IDLE: begin
            if (status_take) next_state = sps_pkg::ST_WORD1;
         end
         sps_pkg::ST_WORD1: begin
            if (beat_take) next_state = sps_pkg::ST_WORD2;
         end
         sps_pkg::ST_WORD2: begin
            if (beat_take) next_state = sps_pkg::ST_IDLE;
         end
         default: next_state = sps_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= sps_pkg::ST_IDLE;
         snap_flags <= sps_pkg::RST_WORD;
         snap_count <= sps_pkg::RST_WORD;
         dest_bit <= 1'b0;
         dest_off <= sps_pkg::RST_WORD;
         cmd_done <= 1'b0;
      end else begin
         state <= next_state;
         cmd_done <= flush || ctrl_take ||
                     (state == sps_pkg::ST_WORD2 && beat_take) ||
                     (cmd_take && !status_take && !flush && !ctrl_take);
         if (status_take) begin
            snap_flags <= flag_word;
            snap_count <= count16;
            dest_bit <= (cmd_arg0 == sps_pkg::MEM_BIT_TYPE);
            dest_off <= cmd_arg1;
         end
      end
   end

   sps_beat_buf #(.W(sps_pkg::BEAT_W), .DEPTH(sps_pkg::OUT_DEPTH)) u_buf (
      .ref_clk(ref_clk),
      .rst(rst),
      .fill(beat_in.snk),
      .drain(beat_out.src)
   );

   assign st_valid = beat_out.valid;
   assign beat_out.ready = st_ready;
   assign st_bit_mode = beat_out.data[32];
   assign st_addr = beat_out.data[31:16];
   assign st_data = beat_out.data[15:0];

   // ****************************************
   // rts control
   // ****************************************
   logic rts_cmd;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rts_cmd <= sps_pkg::RST_RTS;
      end else if (ctrl_take) begin
         rts_cmd <= cmd_arg0[sps_pkg::RTS_BIT];
      end
   end

   wire p2p = (duplex_mode == sps_pkg::DPX_P2P);
   assign tx_drv_en = p2p || tx_active;
   assign rts_line = rts_cmd && (!IS_RS485 || tx_drv_en);

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence seq_status_cmd;
      status_take;
   endsequence
   sequence seq_word1_taken;
      in_word1 && beat_take;
   endsequence

   AST_FLUSH_EMPTY:
   assert property (flush |=> count == '0 && !rx_data_present)
      else $error("flush left characters");
   AST_SNAP_FLAGS:
   assert property (seq_status_cmd |=> in_word1 && beat_word ==
                    {$past(flag_word[15:5]), sps_pkg::UNUSED_BITS})
      else $error("status word one mismatch");
   AST_WORD2:
   assert property (seq_word1_taken |=> state == sps_pkg::ST_WORD2 &&
                    beat_addr == dest_off + stride)
      else $error("second status unit wrong");
   AST_RI:
   assert property (rd_start |=> read_in_progress)
      else $error("read busy not set");
   AST_RI_END:
   assert property (rd_end && !rd_start |=> !read_in_progress)
      else $error("read busy not cleared");
   AST_RS_RT:
   assert property (rd_start && !rd_done && !rd_timeout |=>
                    !read_done_ok && !read_timed_out)
      else $error("read result not cleared");
   AST_RT:
   assert property (rd_timeout |=> read_timed_out)
      else $error("read timeout lost");
   AST_WI:
   assert property (wr_start |=> write_busy)
      else $error("write busy not set");
   AST_WS_CLR:
   assert property (wr_start && !wr_done |=> !write_done_ok)
      else $error("write success not cleared");
   AST_WS_SET:
   assert property (wr_done |=> write_done_ok)
      else $error("write success lost");
   AST_WS_WT:
   assert property (wr_timeout |=> write_timed_out)
      else $error("write timeout lost");
   AST_CA:
   assert property (push && empty |=> rx_data_present)
      else $error("data present not set");
   AST_STICKY:
   assert property (status_take && !rx_frame_err |=> !frame_err)
      else $error("framing error not cleared");
   AST_SET_WINS:
   assert property (status_take && ovf_set |=> overrun_flag)
      else $error("overrun lost at read");
   AST_POP:
   assert property (pop |=> pop_ack)
      else $error("pop not acknowledged");
   AST_RTS:
   assert property (ctrl_take && cmd_arg0[sps_pkg::RTS_BIT] && p2p |=>
                    rts_cmd && (p2p -> rts_line))
      else $error("rts not asserted");
   AST_RTS_GATE:
   assert property (IS_RS485 && !tx_drv_en |-> !rts_line)
      else $error("rts seen without driver");
endmodule : sps_port_status

// ==== design/sps_pkg.sv ====
package sps_pkg;
   // command codes
   localparam logic [15:0] CMD_FLUSH = 16'h10CE;
   localparam logic [15:0] CMD_STATUS = 16'h10CF;
   localparam logic [15:0] CMD_CTRL = 16'h10D0;
   // destination memory type that selects bit addressing
   localparam logic [15:0] MEM_BIT_TYPE = 16'h004C;
   // flag word bit positions
   localparam int POS_RD_BUSY = 15;
   localparam int POS_RD_OK = 14;
   localparam int POS_RD_TMO = 13;
   localparam int POS_WR_BUSY = 12;
   localparam int POS_WR_OK = 11;
   localparam int POS_WR_TMO = 10;
   localparam int POS_RX_AVAIL = 9;
   localparam int POS_OVERRUN = 8;
   localparam int POS_FRAMING = 7;
   localparam int POS_PARITY = 6;
   localparam int POS_CTS = 5;
   localparam int RTS_BIT = 15;
   localparam logic [4:0] UNUSED_BITS = 5'h00;
   // input buffer size in bytes
   localparam int BUF_DEPTH = 2048;
   // address step to the second status word
   localparam logic [15:0] BIT_STRIDE = 16'h0010;
   localparam logic [15:0] WORD_STRIDE = 16'h0001;
   // values after reset
   localparam logic RST_RTS = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam int OUT_DEPTH = 2;
   localparam int BEAT_W = 33;

   typedef enum logic [1:0] {
      DPX_P2P = 2'b00,
      DPX_2W = 2'b01,
      DPX_4W = 2'b10
   } sps_duplex_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WORD1 = 2'b01,
      ST_WORD2 = 2'b10
   } sps_state_t;
endpackage : sps_pkg

// ==== design/sps_beat_if.sv ====
`timescale 1ns/1ps
interface sps_beat_if #(parameter int W = 33) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface : sps_beat_if

// ==== design/sps_beat_buf.sv ====
`timescale 1ns/1ps
// small fifo between the status sequencer and the result port
module sps_beat_buf #(
   parameter int W = 33,
   parameter int DEPTH = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   sps_beat_if.snk fill,
   sps_beat_if.src drain
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   wire push = fill.valid && fill.ready;
   wire pop = drain.valid && drain.ready;
   wire [AW-1:0] next_wp = (wp == LAST) ? '0 : wp + 1'b1;
   wire [AW-1:0] next_rp = (rp == LAST) ? '0 : rp + 1'b1;

   assign fill.ready = (cnt != FULL);
   assign drain.valid = (cnt != '0);
   assign drain.data = mem[rp];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wp] <= fill.data;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) wp <= next_wp;
         if (pop) rp <= next_rp;
         cnt <= cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : sps_beat_buf

// ==== bench/sps_remote_dev.sv ====
`timescale 1ns/1ps
// ************************************
// remote serial device model
// ************************************
// sends one char or one line error per request, one cycle after it
module sps_remote_dev (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [7:0] ch,
   input wire logic [1:0] kind,
   input wire logic cts_on,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic [2:0] err,
   output logic cts_pin
);
   logic [7:0] last = 8'h00;
   logic is_ch;
   assign is_ch = go && kind == 2'h0;
   // idle data line shows the inverse of the last char
   always @(negedge ref_clk) begin
      rx_valid <= is_ch;
      rx_data <= is_ch ? ch : ~last;
      if (is_ch) last <= ch;
      err <= go ? {kind == 2'h1, kind == 2'h2, kind == 2'h3} : 3'h0;
      cts_pin <= cts_on;
   end
endmodule : sps_remote_dev

// ==== bench/serial_port_status_control_test.sv ====
`timescale 1ns/1ps
module serial_port_status_control_test;
   localparam int DEP = 4;
   logic ref_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, pop_req = 1'b0;
   logic st_ready = 1'b1, tx_active = 1'b0, go = 1'b0, cts_on = 1'b1;
   logic [15:0] cmd_code = 16'h0000, cmd_arg0 = 16'h0000;
   logic [15:0] cmd_arg1 = 16'h0000, off;
   logic [1:0] duplex_mode = 2'b00, kind = 2'h0;
   logic [7:0] ev = 8'h00, ch = 8'h00;
   wire cmd_ready, cmd_done, rx_valid, pop_ack, rts_line, tx_drv_en;
   wire st_valid, st_bit_mode, cts_pin;
   wire [7:0] rx_data, pop_data;
   wire [2:0] err;
   wire [15:0] st_addr, st_data;
   int miscompares = 0, n_checks = 0, cnt = 0;
   logic [31:0] seed = 32'h0000CDA2;
   logic [5:0] mf = 6'h00;
   logic [2:0] sticky = 3'h0;
   logic rts_m = 1'b0, ub;
   logic [7:0] q[$];
   logic [15:0] ud[2], ua[2];

   sps_port_status #(.BUF_DEPTH(DEP), .IS_RS485(1'b1)) dut_u (
      .ref_clk(ref_clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
      .cmd_arg0(cmd_arg0), .cmd_arg1(cmd_arg1), .cmd_done(cmd_done),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_overrun(err[2]),
      .rx_frame_err(err[1]), .rx_parity_err(err[0]), .pop_req(pop_req),
      .pop_ack(pop_ack), .pop_data(pop_data), .rd_start(ev[0]),
      .rd_done(ev[1]), .rd_timeout(ev[2]), .rd_cancel(ev[3]),
      .wr_start(ev[4]), .wr_done(ev[5]), .wr_timeout(ev[6]),
      .wr_cancel(ev[7]), .tx_active(tx_active), .duplex_mode(duplex_mode),
      .cts_pin(cts_pin), .rts_line(rts_line), .tx_drv_en(tx_drv_en),
      .st_valid(st_valid), .st_ready(st_ready), .st_bit_mode(st_bit_mode),
      .st_addr(st_addr), .st_data(st_data));

   sps_remote_dev far_u (.ref_clk(ref_clk), .go(go), .ch(ch), .kind(kind),
      .cts_on(cts_on), .rx_valid(rx_valid), .rx_data(rx_data), .err(err),
      .cts_pin(cts_pin));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ************************************
   // expectation helpers
   // ************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [15:0] flags();
      return {mf, cnt != 0, sticky, cts_on, sps_pkg::UNUSED_BITS};
   endfunction : flags

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic check(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic tdone(input string nm);
      $display("test done: %s", nm);
   endtask : tdone

   // ************************************
   // drivers
   // ************************************
   task automatic cmd(input logic [15:0] c, a0, a1);
      int n;
      @(negedge ref_clk);
      cmd_code = c;
      cmd_arg0 = a0;
      cmd_arg1 = a1;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      if (cmd_ready !== 1'b1) begin
         miscompares++;
         close_out();
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
   endtask : cmd

   task automatic status(input logic [15:0] ty);
      int n, u;
      logic bm;
      bm = ty == sps_pkg::MEM_BIT_TYPE;
      off = 16'(rnd());
      cmd(sps_pkg::CMD_STATUS, ty, off);
      u = 0;
      n = 0;
      while (u < 2 && n < 100) begin
         st_ready = rnd() % 3 != 0;
         if (st_valid === 1'b1 && st_ready) begin
            ud[u] = st_data;
            ua[u] = st_addr;
            ub = st_bit_mode;
            u++;
         end
         @(negedge ref_clk);
         n++;
      end
      st_ready = 1'b1;
      if (u < 2) begin
         miscompares++;
         close_out();
      end
      check("flag word", ud[0], flags());
      check("unread count", ud[1], 16'(cnt));
      check("addr one", ua[0], off);
      check("addr two", ua[1], off + (bm ? sps_pkg::BIT_STRIDE :
         sps_pkg::WORD_STRIDE));
      check("bit mode", ub, bm);
      sticky = 3'h0;
   endtask : status

   task automatic send(input logic [7:0] c, input logic [1:0] k);
      ch <= c;
      kind <= k;
      go <= 1'b1;
      @(negedge ref_clk);
      go <= 1'b0;
      repeat (2) @(negedge ref_clk);
      if (k != 2'h0) sticky[3 - k] = 1'b1;
      else if (cnt == DEP) sticky[2] = 1'b1;
      else begin
         cnt++;
         q.push_back(c);
      end
   endtask : send

   task automatic pulse(input int k);
      int o;
      o = k < 4 ? 3 : 0;
      ev[k] = 1'b1;
      @(negedge ref_clk);
      ev = 8'h00;
      @(negedge ref_clk);
      case (k % 4)
         0: mf[o+:3] = 3'b100;
         1: mf[o+2-:2] = 2'b01;
         2: {mf[o+2], mf[o]} = 2'b01;
         default: mf[o+2] = 1'b0;
      endcase
   endtask : pulse

   task automatic pop();
      pop_req = 1'b1;
      @(negedge ref_clk);
      pop_req = 1'b0;
      check("pop ack", pop_ack, 1'b1);
      check("pop data", pop_data, q.pop_front());
      cnt--;
      @(negedge ref_clk);
   endtask : pop

   // ************************************
   // main sequence
   // ************************************
   initial begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      check("ready", cmd_ready, 1'b1);
      check("rts", rts_line, 1'b0);
      check("st valid", st_valid, 1'b0);
      repeat (2) @(negedge ref_clk);
      status(16'h0008);
      tdone("empty status");
      repeat (3) send(8'(rnd()), 2'h0);
      status(sps_pkg::MEM_BIT_TYPE);
      pop();
      status(16'h0008);
      cmd(sps_pkg::CMD_FLUSH, 16'h0000, 16'h0000);
      check("flush done", cmd_done, 1'b1);
      cmd(16'h0000, 16'h0000, 16'h0000);
      check("other done", cmd_done, 1'b1);
      q.delete();
      cnt = 0;
      status(16'h0008);
      tdone("flush");
      repeat (DEP + 1) send(8'(rnd()), 2'h0);
      send(8'h00, 2'h2);
      send(8'h00, 2'h3);
      send(8'h00, 2'h1);
      status(sps_pkg::MEM_BIT_TYPE);
      status(16'h0008);
      while (cnt > 0) pop();
      status(16'h0008);
      tdone("overrun and errors");
      for (int k = 0; k < 8; k++) begin
         pulse(k);
         status(16'h0008);
      end
      repeat (24) begin
         pulse(rnd() % 8);
         if (rnd() % 3 == 0) status(16'h0008);
      end
      cts_on <= 1'b0;
      repeat (4) @(negedge ref_clk);
      status(16'h0008);
      cts_on <= 1'b1;
      repeat (4) @(negedge ref_clk);
      status(16'h0008);
      tdone("events and cts");
      for (int r = 0; r < 2; r++) begin
         cmd(sps_pkg::CMD_CTRL, r ? 16'h8000 : 16'h0000, 16'h0000);
         check("ctrl done", cmd_done, 1'b1);
         rts_m = r[0];
         for (int m = 0; m < 6; m++) begin
            duplex_mode = 2'(m / 2);
            tx_active = m[0];
            @(negedge ref_clk);
            check("drv en", tx_drv_en, m < 2 || m[0]);
            check("rts line", rts_line,
               rts_m && (m < 2 || m[0]));
         end
      end
      tdone("rts and duplex");
      close_out();
   end
endmodule : serial_port_status_control_test
